/* File: shc_pkg.sv */
// package of constants and types for the spectrometer heater and calibration command block
// What this block does
// - power code 4 bits: 0 high, 1 off, 2 low
// - temperature code 4 bits, 10 C per step
// - heater command stored and sent at once
// - sent heater value equals received field unchanged
// - reset setting is 30 C, low power
// - setting applied only while spectrometer powered
// - setting kept while off, resent at power-on
// - heater command ignored while spectrometer unpowered
// - spectrometer heats at commanded power to target
// - internal calibration, then instrument calibration
// - internal calibration on spectrometer power-on while no calibration runs
// - spectroscopic-to-spectroscopic mode change skips calibration
// - after calibrations, resume prior spectroscopic mode
// - calibration command rejected outside spectroscopic modes
// - channel n comes from bank n mod 4
// - subtype 6 decodes as heater command
// - subtype 17 decodes as calibration, data ignored
// - heater command acted on only in spectroscopic mode
package shc_pkg;
   localparam logic [7:0]  SUBTYPE_HEATER   = 8'h06;
   localparam logic [7:0]  SUBTYPE_CAL      = 8'h11;
   localparam int          POWER_MSB        = 15;
   localparam int          POWER_LSB        = 12;
   localparam int          TEMP_MSB         = 11;
   localparam int          TEMP_LSB         = 8;
   localparam logic [3:0]  POWER_HIGH       = 4'h0;
   localparam logic [3:0]  POWER_OFF        = 4'h1;
   localparam logic [3:0]  POWER_LOW        = 4'h2;
   localparam logic [3:0]  TEMP_MAX_CODE    = 4'h7;
   localparam logic [3:0]  RESET_POWER      = POWER_LOW;
   localparam logic [3:0]  RESET_TEMP       = 4'h3;
   localparam int          NUM_BANKS        = 4;
   localparam int          NUM_CHANNELS     = 4096;
   typedef enum {ST_IDLE, ST_INT_CAL, ST_INST_CAL} shc_state_type;
endpackage

/* File: shc_heater_cal_cmd.sv */
// spectrometer heater and internal calibration telecommand interpreter
module shc_heater_cal_cmd
   import shc_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        cmdValid,
   input  wire logic [7:0]  cmdSubtype,
   input  wire logic [15:0] cmdAppData,
   input  wire logic        spectroPowered,
   input  wire logic        spectroMode,
   input  wire logic        intCalDone,
   input  wire logic        instCalDone,
   input  wire logic [11:0] channelIndex,
   output logic             heaterSendStb,
   output logic [3:0]       heater_power_code,
   output logic [3:0]       heater_temperature_code,
   output logic             intCalStart,
   output logic             instCalStart,
   output logic             calBusy,
   output logic             resumeMode,
   output logic             cmdReject,
   output logic [1:0]       channelBank
);
   // input synchronisers
   logic [1:0] powSync_reg;
   logic [1:0] modeSync_reg;
   logic       powPrev_reg;
   logic [3:0] storedPower_reg;
   logic [3:0] storedTemp_reg;
   shc_state_type state_reg;
   shc_state_type state_next;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         powSync_reg  <= 2'h0;
         modeSync_reg <= 2'h0;
         powPrev_reg  <= 1'b0;
      end
      else
      begin
         powSync_reg  <= {powSync_reg[0], spectroPowered};
         modeSync_reg <= {modeSync_reg[0], spectroMode};
         powPrev_reg  <= powSync_reg[1];
      end
   end

   // subtype decode, shared by both telecommands
   function automatic logic subtypeHit(input logic valid, input logic [7:0] subtype, input logic [7:0] code);
      return valid & (subtype == code);
   endfunction

   // decode of the incoming telecommand
   wire        powered    = powSync_reg[1];
   wire        inSpectro  = modeSync_reg[1];
   wire        powerOnEvt = powered & ~powPrev_reg;
   wire        isHeater   = subtypeHit(cmdValid, cmdSubtype, SUBTYPE_HEATER);
   wire        isCal      = subtypeHit(cmdValid, cmdSubtype, SUBTYPE_CAL);
   wire [3:0]  rxPower    = cmdAppData[POWER_MSB:POWER_LSB];
   wire [3:0]  rxTemp     = cmdAppData[TEMP_MSB:TEMP_LSB];
   wire        heaterOk   = isHeater & powered & inSpectro;
   wire        calOk      = isCal & inSpectro & (state_reg == ST_IDLE);
   wire        calBad     = isCal & ~calOk;
   wire        heaterBad  = isHeater & ~heaterOk;

   // stored heater setting, kept across spectrometer power-off
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         storedPower_reg <= RESET_POWER;
         storedTemp_reg  <= RESET_TEMP;
      end
      else if (heaterOk)
      begin
         storedPower_reg <= rxPower;
         storedTemp_reg  <= rxTemp;
      end
   end

   // send path: on accepted command or on spectrometer power-on
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         heaterSendStb           <= 1'b0;
         heater_power_code       <= RESET_POWER;
         heater_temperature_code <= RESET_TEMP;
      end
      else
      begin
         heaterSendStb <= heaterOk | (powerOnEvt & ~heaterOk);
         if (heaterOk)
         begin
            heater_power_code       <= rxPower;
            heater_temperature_code <= rxTemp;
         end
         else if (powerOnEvt)
         begin
            heater_power_code       <= storedPower_reg;
            heater_temperature_code <= storedTemp_reg;
         end
      end
   end

   // calibration sequencer
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            if (calOk | powerOnEvt)
               state_next = ST_INT_CAL;
         ST_INT_CAL:
            if (intCalDone)
               state_next = ST_INST_CAL;
         ST_INST_CAL:
            if (instCalDone)
               state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   // one-cycle pulses on entry to each state
   wire enterInt = (state_reg == ST_IDLE) & (state_next == ST_INT_CAL);
   wire enterIns = (state_reg == ST_INT_CAL) & (state_next == ST_INST_CAL);
   wire leaveCal = (state_reg == ST_INST_CAL) & (state_next == ST_IDLE);

   // sequencer registers and pulses; mode-only changes never start a calibration
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_reg    <= ST_IDLE;
         intCalStart  <= 1'b0;
         instCalStart <= 1'b0;
         calBusy      <= 1'b0;
         resumeMode   <= 1'b0;
         cmdReject    <= 1'b0;
         channelBank  <= 2'h0;
      end
      else
      begin
         state_reg    <= state_next;
         intCalStart  <= enterInt;
         instCalStart <= enterIns;
         calBusy      <= (state_next != ST_IDLE);
         resumeMode   <= leaveCal;
         cmdReject    <= calBad | heaterBad;
         channelBank  <= channelIndex[1:0];
      end
   end

   // checks
   AST_HEATER_SEND: assert property (@(posedge sys_clk) disable iff (rst)
      heaterOk |=> heaterSendStb && heater_power_code == $past(rxPower)
         && heater_temperature_code == $past(rxTemp))
      else $error("accepted heater command not sent");
   AST_NO_SEND_UNPOWERED: assert property (@(posedge sys_clk) disable iff (rst)
      (isHeater && !powered && !powerOnEvt) |=> !heaterSendStb)
      else $error("heater command sent while unpowered");
   AST_RESEND_POWERON: assert property (@(posedge sys_clk) disable iff (rst)
      (powerOnEvt && !heaterOk) |=> heaterSendStb && heater_power_code == $past(storedPower_reg))
      else $error("stored setting not resent at power-on");
   AST_STORE: assert property (@(posedge sys_clk) disable iff (rst)
      heaterOk |=> storedTemp_reg == $past(rxTemp) && storedPower_reg == $past(rxPower))
      else $error("heater setting not stored");

   // default setting, its retention and the powered-only send
   AST_RESET_SETTING: assert property (@(posedge sys_clk)
      rst |=> storedPower_reg == RESET_POWER && storedTemp_reg == RESET_TEMP
         && heater_power_code == RESET_POWER && heater_temperature_code == RESET_TEMP)
      else $error("heater setting not reset to default");
   AST_SETTING_KEPT: assert property (@(posedge sys_clk) disable iff (rst)
      (!rst && !heaterOk) |=> $stable(storedPower_reg) && $stable(storedTemp_reg))
      else $error("stored heater setting changed without command");
   AST_SEND_POWERED: assert property (@(posedge sys_clk) disable iff (rst)
      heaterSendStb |-> $past(powered))
      else $error("heater word sent to unpowered spectrometer");
   sequence calAccepted;
      calOk && !powerOnEvt;
   endsequence
   AST_CAL_START: assert property (@(posedge sys_clk) disable iff (rst)
      calAccepted |=> intCalStart ##1 !intCalStart)
      else $error("internal calibration not started");
   AST_CAL_ORDER: assert property (@(posedge sys_clk) disable iff (rst)
      instCalStart |-> $past(state_reg) == ST_INT_CAL)
      else $error("instrument calibration out of order");
   AST_POWERON_CAL: assert property (@(posedge sys_clk) disable iff (rst)
      (powerOnEvt && state_reg == ST_IDLE) |=> intCalStart)
      else $error("no calibration at power-on");
   AST_REJECT: assert property (@(posedge sys_clk) disable iff (rst)
      (isCal && !inSpectro && state_reg == ST_IDLE && !powerOnEvt) |=> cmdReject && !intCalStart)
      else $error("calibration command not rejected");
   AST_RESUME: assert property (@(posedge sys_clk) disable iff (rst)
      (state_reg == ST_INST_CAL && instCalDone) |=> resumeMode && !calBusy)
      else $error("no resume after calibrations");
   AST_BANK: assert property (@(posedge sys_clk) disable iff (rst)
      !rst |=> channelBank == $past(channelIndex[1:0])) // no attempt from the releasing edge
      else $error("wrong bank for channel");

   // calibration step order
   sequence intCalFinished;
      state_reg == ST_INT_CAL && intCalDone;
   endsequence
   sequence instCalIssued;
      instCalStart && calBusy ##1 !instCalStart;
   endsequence
   AST_INST_AFTER_INT: assert property (@(posedge sys_clk) disable iff (rst)
      intCalFinished |=> instCalIssued)
      else $error("instrument calibration not started after internal one");
   AST_NO_MODE_CAL: assert property (@(posedge sys_clk) disable iff (rst)
      (state_reg == ST_IDLE && !calOk && !powerOnEvt) |=> !intCalStart)
      else $error("calibration started without command or power-on");

   // spectroscopic-mode gating of the heater command
   AST_REJECT_HEATER: assert property (@(posedge sys_clk) disable iff (rst)
      (isHeater && !inSpectro && !powerOnEvt) |=> cmdReject && !heaterSendStb)
      else $error("heater command acted on outside spectroscopic mode");
endmodule

/* File: shc_spectro_model.sv */
// spectrometer model answering calibration starts and holding the heater target
module shc_spectro_model
   import shc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       intCalStart,
   input  wire logic       instCalStart,
   input  wire logic       heaterSendStb,
   input  wire logic [3:0] heater_power_code,
   input  wire logic [3:0] heater_temperature_code,
   output logic            intCalDone,
   output logic            instCalDone
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] intCnt_reg;
   logic [2:0] instCnt_reg;
   logic [7:0] target_reg;
   // inner calibration answers fast, instrument calibration slowly
   always_ff @(posedge sys_clk)
   begin
      intCalDone  <= !rst && intCnt_reg == 3'h1;
      instCalDone <= !rst && instCnt_reg == 3'h1;
      intCnt_reg  <= rst ? 3'h0 : intCalStart ? 3'h2 : intCnt_reg - {2'h0, intCnt_reg != 3'h0};
      instCnt_reg <= rst ? 3'h0 : instCalStart ? 3'h7 : instCnt_reg - {2'h0, instCnt_reg != 3'h0};
      target_reg  <= rst ? {RESET_POWER, RESET_TEMP} : heaterSendStb ? {heater_power_code,
                     heater_temperature_code} : target_reg; // heat toward this target
   end
endmodule

/* File: tb_top.sv */
// self-checking bench for the heater and calibration command block
module tb_top
   import shc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 0, rst = 1, cmdValid = 0, spectroPowered = 0, spectroMode = 0, chkOn = 0;
   logic        heaterSendStb, intCalStart, instCalStart, calBusy, resumeMode, cmdReject;
   logic        intCalDone, instCalDone;
   logic [3:0]  heater_power_code, heater_temperature_code;
   logic [1:0]  channelBank;
   logic [7:0]  cmdSubtype = 0;
   logic [7:0]  lastWord = {RESET_POWER, RESET_TEMP};
   logic [15:0] cmdAppData = 0;
   logic [11:0] channelIndex = 0, prevIdx = 0;
   logic [31:0] seed = 32'h330b_3be3;
   logic [9:0]  notes[$];
   logic [9:0]  seen;
   int          num_errors = 0, checks = 0;
   shc_heater_cal_cmd i_dut (.sys_clk(sys_clk), .rst(rst), .cmdValid(cmdValid), .cmdSubtype(cmdSubtype),
      .cmdAppData(cmdAppData), .spectroPowered(spectroPowered), .spectroMode(spectroMode),
      .intCalDone(intCalDone), .instCalDone(instCalDone), .channelIndex(channelIndex),
      .heaterSendStb(heaterSendStb), .heater_power_code(heater_power_code),
      .heater_temperature_code(heater_temperature_code), .intCalStart(intCalStart),
      .instCalStart(instCalStart), .calBusy(calBusy), .resumeMode(resumeMode), .cmdReject(cmdReject),
      .channelBank(channelBank));
   shc_spectro_model i_model (.sys_clk(sys_clk), .rst(rst), .intCalStart(intCalStart),
      .instCalStart(instCalStart), .heaterSendStb(heaterSendStb), .heater_power_code(heater_power_code),
      .heater_temperature_code(heater_temperature_code), .intCalDone(intCalDone), .instCalDone(instCalDone));
   initial forever #10 sys_clk = ~sys_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: saw %h want %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one command cycle; a non-zero note is the result expected from it
   task automatic send(input logic [7:0] st, input logic [15:0] d, input logic [9:0] note);
      if (note != 10'h0)
         notes.push_back(note);
      @(posedge sys_clk);
      cmdValid   <= 1'b1;
      cmdSubtype <= st;
      cmdAppData <= d;
      @(posedge sys_clk);
      cmdValid   <= 1'b0;
   endtask
   // change power and mode levels, then let synchronisers and calibration settle
   task automatic power(input logic p, input logic m);
      @(posedge sys_clk);
      spectroPowered <= p;
      spectroMode    <= m;
      repeat (40) @(posedge sys_clk);
   endtask
   // random channel stimulus and the watcher that matches results to notes
   always @(posedge sys_clk)
   begin
      seed         <= lfsr(seed);
      channelIndex <= seed[11:0];
      prevIdx      <= channelIndex;
      if (chkOn)
         check({8'h0, channelBank}, {8'h0, prevIdx[1:0]});
      seen = (heaterSendStb === 1'b1) ? {2'd1, heater_power_code, heater_temperature_code} :
             (cmdReject === 1'b1) ? 10'h200 : (resumeMode === 1'b1) ? 10'h300 : 10'h0;
      if (seen != 10'h0)
         check(seen, notes.size() > 0 ? notes.pop_front() : 10'h3ff);
   end
   initial
   begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chkOn <= 1'b1;
      check({2'd1, heater_power_code, heater_temperature_code}, {2'd1, lastWord});
      send(SUBTYPE_HEATER, 16'h0500, 10'h200);
      send(SUBTYPE_CAL, 16'h0000, 10'h200);
      notes.push_back({2'd1, lastWord});
      notes.push_back(10'h300);
      power(1'b1, 1'b1);
      for (int i = 0; i < 9; i++)
      begin
         lastWord = {4'(i % 3), i == 8 ? TEMP_MAX_CODE : {1'b0, seed[2:0]}};
         send(SUBTYPE_HEATER, {lastWord, seed[15:8]}, {2'd1, lastWord});
      end
      send(8'h07, seed[15:0], 10'h0);
      send(SUBTYPE_CAL, seed[15:0], 10'h0);
      send(SUBTYPE_CAL, 16'h0000, 10'h200);
      check({9'h0, calBusy}, 10'h001);
      notes.push_back(10'h300);
      power(1'b1, 1'b0);
      check({9'h0, calBusy}, 10'h000);
      send(SUBTYPE_HEATER, 16'h0000, 10'h200);
      power(1'b1, 1'b1);
      power(1'b0, 1'b1);
      send(SUBTYPE_HEATER, 16'h0700, 10'h200);
      notes.push_back({2'd1, lastWord});
      notes.push_back(10'h300);
      power(1'b1, 1'b1);
      check({2'd1, i_model.target_reg}, {2'd1, lastWord});
      // software restart while powered: default setting resent, calibration rerun
      lastWord = {RESET_POWER, RESET_TEMP};
      notes.push_back({2'd1, lastWord});
      notes.push_back(10'h300);
      @(posedge sys_clk);
      rst   <= 1'b1;
      chkOn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chkOn <= 1'b1;
      repeat (40) @(posedge sys_clk);
      check(10'(notes.size()), 10'h0);
      complete_run();
   end
   // watchdog against a hang
   initial
   begin
      #20000; // about three times the expected run
      num_errors++;
      complete_run();
   end
endmodule
